//--- core/nvp_pkg.sv
package nvp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Frame layout
    localparam logic [7:0]  NVP_PREAMBLE_BYTE = 8'h55;
    localparam logic [15:0] NVP_PKT_TYPE      = 16'h4E31;
    localparam logic [7:0]  NVP_PKT_LEN       = 8'h2A;
    localparam int          NVP_PAY_BYTES     = 42;
    localparam logic [5:0]  NVP_IDX_TYPE_HI   = 6'h02;
    localparam logic [5:0]  NVP_IDX_TYPE_LO   = 6'h03;
    localparam logic [5:0]  NVP_IDX_LEN       = 6'h04;
    localparam logic [5:0]  NVP_IDX_PAY0      = 6'h05;
    localparam logic [5:0]  NVP_IDX_PAY_LAST  = 6'h2E;
    localparam logic [5:0]  NVP_IDX_CRC_HI    = 6'h2F;
    localparam logic [5:0]  NVP_IDX_CRC_LO    = 6'h30;

    // Payload byte offsets
    localparam int NVP_OFS_ROLL   = 0;
    localparam int NVP_OFS_PITCH  = 2;
    localparam int NVP_OFS_HEAD   = 4;
    localparam int NVP_OFS_XRATE  = 6;
    localparam int NVP_OFS_YRATE  = 8;
    localparam int NVP_OFS_ZRATE  = 10;
    localparam int NVP_OFS_XACC   = 12;
    localparam int NVP_OFS_YACC   = 14;
    localparam int NVP_OFS_ZACC   = 16;
    localparam int NVP_OFS_NORTH_VELOCITY_WORD   = 18;
    localparam int NVP_OFS_EAST_VELOCITY_WORD   = 20;
    localparam int NVP_OFS_DOWN_VELOCITY_WORD   = 22;
    localparam int NVP_OFS_LON    = 24;
    localparam int NVP_OFS_LAT    = 28;
    localparam int NVP_OFS_ALT    = 32;
    localparam int NVP_OFS_TEMP   = 34;
    localparam int NVP_OFS_TOW    = 36;
    localparam int NVP_OFS_HEALTH = 40;

    ////////////////////////////////////////////////////////////////////////
    // Configuration field identifiers
    localparam logic [3:0] NVP_FLD_RATE_DIV = 4'h1;
    localparam logic [3:0] NVP_FLD_BAUD     = 4'h2;
    localparam logic [3:0] NVP_FLD_PKT_TYPE = 4'h3;
    localparam logic [3:0] NVP_FLD_UNUSED   = 4'h4;
    localparam logic [3:0] NVP_FLD_GYRO_FLT = 4'h5;
    localparam logic [3:0] NVP_FLD_ACC_FLT  = 4'h6;
    localparam logic [3:0] NVP_FLD_ORIENT   = 4'h7;
    localparam logic [3:0] NVP_FLD_BEHAV    = 4'h8;
    localparam logic [3:0] NVP_FLD_HARD_X   = 4'h9;
    localparam logic [3:0] NVP_FLD_HARD_Y   = 4'hA;
    localparam logic [3:0] NVP_FLD_SOFT     = 4'hB;
    localparam logic [3:0] NVP_FLD_TRACK    = 4'hC;
    localparam int         NVP_NUM_FIELDS   = 16;

    // Factory contents of the stored bank
    localparam logic [15:0] NVP_FIELD_RESET [NVP_NUM_FIELDS] = '{
        16'h0000, 16'h0001, 16'h0002, 16'h4E31,
        16'h0000, 16'h0000, 16'h0000, 16'h0009,
        16'h0000, 16'h0000, 16'h0000, 16'h8000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // Filter bands and cutoff codes
    localparam logic [15:0] NVP_BAND_5HZ  = 16'h1BE6;
    localparam logic [15:0] NVP_BAND_10HZ = 16'h0DF3;
    localparam logic [15:0] NVP_BAND_20HZ = 16'h05FA;
    localparam logic [1:0]  NVP_CUT_5HZ   = 2'h0;
    localparam logic [1:0]  NVP_CUT_10HZ  = 2'h1;
    localparam logic [1:0]  NVP_CUT_20HZ  = 2'h2;
    localparam logic [1:0]  NVP_CUT_50HZ  = 2'h3;
    localparam logic [15:0] NVP_BAUD_MAX  = 16'h0003;

    ////////////////////////////////////////////////////////////////////////
    // Register port map
    localparam logic [7:0] NVP_ADDR_CUR_BASE = 8'h00;
    localparam logic [7:0] NVP_ADDR_NV_BASE  = 8'h10;
    localparam logic [7:0] NVP_ADDR_STATUS   = 8'h20;
    localparam logic [7:0] NVP_ADDR_PKT_CNT  = 8'h21;
    localparam int         NVP_ST_REJECT     = 0;
    localparam int         NVP_ST_BUSY       = 1;
    localparam int         NVP_ST_LOADED     = 2;

    ////////////////////////////////////////////////////////////////////////
    // Timing: base packet tick is 100 Hz
    localparam int NVP_CLK_PERIOD_NS = 10;
    localparam int NVP_BASE_TICK_NS  = 10_000_000;
    localparam int NVP_BASE_TICK_CYC = NVP_BASE_TICK_NS / NVP_CLK_PERIOD_NS;

    // CRC defaults
    localparam logic [15:0] NVP_CRC_POLY = 16'h1021;
    localparam logic [15:0] NVP_CRC_INIT = 16'hFFFF;

    typedef enum logic [1:0] {
        NVP_ST_BOOT = 2'b00,
        NVP_ST_IDLE = 2'b01,
        NVP_ST_SEND = 2'b10
    } nvp_state_t;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic orient_ok(input logic [15:0] v);
        orient_ok = v inside {16'h0000, 16'h0009, 16'h0023, 16'h002A,
            16'h0041, 16'h0048, 16'h0062, 16'h006B,
            16'h0085, 16'h008C, 16'h0092, 16'h009B,
            16'h00C4, 16'h00CD, 16'h00D3, 16'h00DA,
            16'h0111, 16'h0118, 16'h0124, 16'h012D,
            16'h0150, 16'h0159, 16'h0165, 16'h016C};
    endfunction : orient_ok

    function automatic logic field_valid(input logic [3:0]  id,
                                         input logic [15:0] v);
        case (id)
            NVP_FLD_RATE_DIV: field_valid = v inside {16'h0000, 16'h0001,
                16'h0002, 16'h0005, 16'h000A, 16'h0014, 16'h0019, 16'h0032};
            NVP_FLD_BAUD:     field_valid = (v <= NVP_BAUD_MAX);
            NVP_FLD_PKT_TYPE: field_valid = (v == NVP_PKT_TYPE);
            NVP_FLD_ORIENT:   field_valid = orient_ok(v);
            NVP_FLD_GYRO_FLT, NVP_FLD_ACC_FLT, NVP_FLD_BEHAV,
            NVP_FLD_HARD_X, NVP_FLD_HARD_Y, NVP_FLD_SOFT,
            NVP_FLD_TRACK:    field_valid = 1'b1;
            default:          field_valid = 1'b0;
        endcase
    endfunction : field_valid

    function automatic logic [1:0] cutoff_band(input logic [15:0] v);
        if (v >= NVP_BAND_5HZ) begin
            cutoff_band = NVP_CUT_5HZ;
        end else if (v >= NVP_BAND_10HZ) begin
            cutoff_band = NVP_CUT_10HZ;
        end else if (v >= NVP_BAND_20HZ) begin
            cutoff_band = NVP_CUT_20HZ;
        end else begin
            cutoff_band = NVP_CUT_50HZ;
        end
    endfunction : cutoff_band

    function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                             input logic [7:0]  b,
                                             input logic [15:0] poly);
        logic [15:0] c;
        c = crc ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ({c[14:0], 1'b0} ^ poly) : {c[14:0], 1'b0};
        end
        crc_step = c;
    endfunction : crc_step

endpackage : nvp_pkg

//--- core/nvp_bank_if.sv
`timescale 1ns/1ps
interface nvp_bank_if;
    import nvp_pkg::*;
    logic        we;
    logic [3:0]  idx;
    logic [15:0] wdata;
    logic        load;
    logic [15:0] load_words [NVP_NUM_FIELDS];
    logic [15:0] words      [NVP_NUM_FIELDS];

    modport ctrl (output we, idx, wdata, load, load_words, input words);
    modport bank (input we, idx, wdata, load, load_words, output words);
endinterface : nvp_bank_if

//--- core/nvp_field_bank.sv
`timescale 1ns/1ps
module nvp_field_bank
    import nvp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Field access
    nvp_bank_if.bank bus
);

    // Whole-bank load takes priority over a single field write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.words <= NVP_FIELD_RESET;
        end else if (bus.load) begin
            bus.words <= bus.load_words;
        end else if (bus.we) begin
            bus.words[bus.idx] <= bus.wdata;
        end
    end

endmodule : nvp_field_bank

//--- core/nvp_framer.sv
`timescale 1ns/1ps
// Functional notes
// R1: Frame: preamble 5555, type 4E31, length 2A, payload, CRC.
// R2: Roll, pitch, true heading at payload bytes 0, 2, 4.
// R3: X, Y, Z corrected rates at bytes 6, 8, 10.
// R4: X, Y, Z acceleration at bytes 12, 14, 16.
// R5: North, east, down velocity at bytes 18, 20, 22.
// R6: Longitude at byte 24, latitude at 28, both 32 bits.
// R7: Shifted two's-complement altitude at byte 32.
// R8: Rate sensor temperature at byte 34.
// R9: Four-byte time-of-week at byte 36, content not guaranteed.
// R10: Master health word at byte 40, last before CRC.
// R11: Working fields load from stored ones at power-up.
// R12: Read stored returns stored; write stored changes only power-up. Reset also reloads the stored bank, so a stored write never reaches working.
// R13: Get current returns working; set current acts immediately.
// R14: Set or write taken only with a valid field value.
// R15: Rate divider 0,1,2,5,10,20,25,50 gives quiet to 2 Hz.
// R16: Serial rate codes 0 to 3 select 9600 to 57600 baud.
// R17: Continuous packet type takes supported types only.
// R18: Rate filter value bands select 5, 10, 20 or 50 Hz.
// R19: Accelerometer filter uses the same four bands.
// R20: Field 7 holds orientation, field 8 behaviour switches.
// R21: Fields 9 to C: iron biases, ratio, track offset.
// R22: Serial rate change applies at once, reply at new rate.
// R23: Host hunts preamble, checks type, length and CRC.
module nvp_framer
    import nvp_pkg::*;
#(
    parameter int          BASE_TICK_CYC = NVP_BASE_TICK_CYC,
    parameter logic [15:0] CRC_POLY      = NVP_CRC_POLY,
    parameter logic [15:0] CRC_INIT      = NVP_CRC_INIT
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic      [15:0] reg_rdata_r,
    // Sensor words
    input  wire logic [15:0] roll_word,
    input  wire logic [15:0] pitch_word,
    input  wire logic [15:0] true_heading_word,
    input  wire logic [15:0] x_rate_word,
    input  wire logic [15:0] y_rate_word,
    input  wire logic [15:0] z_rate_word,
    input  wire logic [15:0] x_accel_word,
    input  wire logic [15:0] y_accel_word,
    input  wire logic [15:0] z_accel_word,
    input  wire logic [15:0] north_velocity_word,
    input  wire logic [15:0] east_velocity_word,
    input  wire logic [15:0] down_velocity_word,
    input  wire logic [31:0] sat_longitude_word,
    input  wire logic [31:0] sat_latitude_word,
    input  wire logic [15:0] sat_altitude_word,
    input  wire logic [15:0] rate_sensor_temp_word,
    input  wire logic [31:0] time_of_week_ms,
    input  wire logic [15:0] master_health_word,
    // Byte stream towards the serial transmitter
    output logic      [7:0]  tx_data_r,
    output logic             tx_valid_r,
    input  wire logic        tx_ready,
    // Working configuration
    output logic      [1:0]  baud_sel_r,
    output logic      [1:0]  gyro_cut_r,
    output logic      [1:0]  accel_cut_r,
    output logic      [8:0]  orient_r,
    output logic      [5:0]  behav_r
);

    ////////////////////////////////////////////////////////////////////////
    // Field banks: stored models the nonvolatile copy
    nvp_bank_if nv_if ();
    nvp_bank_if cur_if ();

    nvp_field_bank u_stored (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (nv_if.bank)
    );

    nvp_field_bank u_current (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (cur_if.bank)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    wire logic       sel_cur   = (reg_addr[7:4] == NVP_ADDR_CUR_BASE[7:4]);
    wire logic       sel_nv    = (reg_addr[7:4] == NVP_ADDR_NV_BASE[7:4]);
    wire logic [3:0] fld_id    = reg_addr[3:0];
    wire logic       wr_ok     = field_valid(fld_id, reg_wdata); // [R14] [R21]
    wire logic       wr_cur    = reg_we && sel_cur;
    wire logic       wr_nv     = reg_we && sel_nv;
    wire logic       wr_reject = (wr_cur || wr_nv) && !wr_ok; // [R14]

    nvp_state_t  state_r;
    nvp_state_t  state_nxt;
    logic        boot_load;

    assign boot_load = (state_r == NVP_ST_BOOT);

    // Stored bank changes only here, never the working set [R12]
    assign nv_if.we         = wr_nv && wr_ok;
    assign nv_if.idx        = fld_id;
    assign nv_if.wdata      = reg_wdata;
    assign nv_if.load       = 1'b0;
    assign nv_if.load_words = NVP_FIELD_RESET;

    // Working bank: loaded from stored, then set
    assign cur_if.we         = wr_cur && wr_ok && !boot_load; // [R13]
    assign cur_if.idx        = fld_id;
    assign cur_if.wdata      = reg_wdata;
    assign cur_if.load       = boot_load; // [R11]
    assign cur_if.load_words = nv_if.words; // [R11]

    ////////////////////////////////////////////////////////////////////////
    // Status and read data
    logic        reject_r;
    logic [15:0] pkt_cnt_r;
    wire  logic  st_read   = reg_re && (reg_addr == NVP_ADDR_STATUS);
    wire  logic  loaded    = (state_r != NVP_ST_BOOT);
    wire  logic  busy      = (state_r == NVP_ST_SEND);

    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (sel_cur) begin
            rd_mux = cur_if.words[fld_id]; // [R13]
        end else if (sel_nv) begin
            rd_mux = nv_if.words[fld_id]; // [R12]
        end else if (reg_addr == NVP_ADDR_STATUS) begin
            rd_mux[NVP_ST_REJECT] = reject_r;
            rd_mux[NVP_ST_BUSY]   = busy;
            rd_mux[NVP_ST_LOADED] = loaded;
        end else if (reg_addr == NVP_ADDR_PKT_CNT) begin
            rd_mux = pkt_cnt_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 16'h0000;
        end else if (reg_re) begin
            reg_rdata_r <= rd_mux;
        end
    end

    // Sticky refusal; set beats a status read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reject_r <= 1'b0;
        end else if (wr_reject) begin
            reject_r <= 1'b1;
        end else if (st_read) begin
            reject_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Config outputs follow the working bank
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_sel_r  <= 2'h0;
            gyro_cut_r  <= NVP_CUT_50HZ;
            accel_cut_r <= NVP_CUT_50HZ;
            orient_r    <= 9'h000;
            behav_r     <= 6'h00;
        end else begin
            baud_sel_r  <= cur_if.words[NVP_FLD_BAUD][1:0]; // [R16] [R22]
            gyro_cut_r  <= cutoff_band(cur_if.words[NVP_FLD_GYRO_FLT]); // [R18]
            accel_cut_r <= cutoff_band(cur_if.words[NVP_FLD_ACC_FLT]);  // [R19]
            orient_r    <= cur_if.words[NVP_FLD_ORIENT][8:0]; // [R20]
            behav_r     <= cur_if.words[NVP_FLD_BEHAV][5:0]; // [R20]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Packet rate: base tick over the divider
    logic [31:0] tick_cnt_r;
    logic [7:0]  div_cnt_r;
    wire  logic [7:0] rate_div = cur_if.words[NVP_FLD_RATE_DIV][7:0];
    wire  logic  base_tick = (tick_cnt_r == 32'(BASE_TICK_CYC - 1));
    wire  logic  quiet     = (rate_div == 8'h00); // [R15]
    wire  logic  div_hit   = base_tick && !quiet &&
                             (div_cnt_r >= rate_div - 8'h01); // [R15]
    // Only the supported type streams; guards a stored bank altered later
    wire  logic  type_on   =
        (cur_if.words[NVP_FLD_PKT_TYPE] == NVP_PKT_TYPE); // [R17]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= 32'h0000_0000;
            div_cnt_r  <= 8'h00;
        end else begin
            tick_cnt_r <= base_tick ? 32'h0000_0000 : tick_cnt_r + 32'h1;
            if (quiet || div_hit) begin
                div_cnt_r <= 8'h00;
            end else if (base_tick) begin
                div_cnt_r <= div_cnt_r + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Payload snapshot, byte 0 at bits 7:0, words big-endian
    logic [NVP_PAY_BYTES*8-1:0] pay_r;
    logic [NVP_PAY_BYTES*8-1:0] pay_nxt;

    function automatic logic [15:0] swap16(input logic [15:0] w);
        swap16 = {w[7:0], w[15:8]};
    endfunction : swap16

    function automatic logic [31:0] swap32(input logic [31:0] w);
        swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap32

    always_comb begin
        pay_nxt = '0;
        pay_nxt[NVP_OFS_ROLL*8 +: 16] = swap16(roll_word); // [R2]
        pay_nxt[NVP_OFS_PITCH*8 +: 16] = swap16(pitch_word); // [R2]
        pay_nxt[NVP_OFS_HEAD*8 +: 16] = swap16(true_heading_word); // [R2]
        pay_nxt[NVP_OFS_XRATE*8 +: 16] = swap16(x_rate_word); // [R3]
        pay_nxt[NVP_OFS_YRATE*8 +: 16] = swap16(y_rate_word); // [R3]
        pay_nxt[NVP_OFS_ZRATE*8 +: 16] = swap16(z_rate_word); // [R3]
        pay_nxt[NVP_OFS_XACC*8 +: 16] = swap16(x_accel_word); // [R4]
        pay_nxt[NVP_OFS_YACC*8 +: 16] = swap16(y_accel_word); // [R4]
        pay_nxt[NVP_OFS_ZACC*8 +: 16] = swap16(z_accel_word); // [R4]
        pay_nxt[NVP_OFS_NORTH_VELOCITY_WORD*8   +: 16] = swap16(north_velocity_word);// [R5]
        pay_nxt[NVP_OFS_EAST_VELOCITY_WORD*8   +: 16] = swap16(east_velocity_word); // [R5]
        pay_nxt[NVP_OFS_DOWN_VELOCITY_WORD*8   +: 16] = swap16(down_velocity_word); // [R5]
        pay_nxt[NVP_OFS_LON*8    +: 32] = swap32(sat_longitude_word); // [R6]
        pay_nxt[NVP_OFS_LAT*8    +: 32] = swap32(sat_latitude_word);  // [R6]
        pay_nxt[NVP_OFS_ALT*8    +: 16] = swap16(sat_altitude_word);  // [R7]
        pay_nxt[NVP_OFS_TEMP*8   +: 16] = swap16(rate_sensor_temp_word);// [R8]
        // Passed through as given; no satellite time alignment here
        pay_nxt[NVP_OFS_TOW*8    +: 32] = swap32(time_of_week_ms);    // [R9]
        pay_nxt[NVP_OFS_HEALTH*8 +: 16] = swap16(master_health_word); // [R10]
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer
    logic [5:0]  idx_r;
    logic [15:0] crc_r;
    wire  logic  accept    = tx_valid_r && tx_ready;
    wire  logic  start     = (state_r == NVP_ST_IDLE) && div_hit && type_on;
    wire  logic  last_byte = (idx_r == NVP_IDX_CRC_LO);
    wire  logic  in_crc    = (idx_r >= NVP_IDX_TYPE_HI) &&
                             (idx_r <= NVP_IDX_PAY_LAST);
    wire  logic [15:0] crc_upd = crc_step(crc_r, tx_data_r, CRC_POLY);
    wire  logic [5:0]  idx_nxt = start ? 6'h00 : idx_r + 6'h01;
    wire  logic [5:0]  pay_idx = idx_nxt - NVP_IDX_PAY0;

    // Byte for the next slot
    logic [7:0] byte_nxt;
    always_comb begin
        byte_nxt = NVP_PREAMBLE_BYTE; // [R1]
        if (idx_nxt == NVP_IDX_TYPE_HI) begin
            byte_nxt = NVP_PKT_TYPE[15:8]; // [R1]
        end else if (idx_nxt == NVP_IDX_TYPE_LO) begin
            byte_nxt = NVP_PKT_TYPE[7:0]; // [R1]
        end else if (idx_nxt == NVP_IDX_LEN) begin
            byte_nxt = NVP_PKT_LEN; // [R1]
        end else if (idx_nxt == NVP_IDX_CRC_HI) begin
            byte_nxt = crc_upd[15:8]; // [R1]
        end else if (idx_nxt == NVP_IDX_CRC_LO) begin
            byte_nxt = crc_r[7:0]; // [R1]
        end else if (idx_nxt >= NVP_IDX_PAY0) begin
            byte_nxt = start ? 8'h00 : pay_r[pay_idx*8 +: 8];
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            NVP_ST_BOOT: state_nxt = NVP_ST_IDLE; // [R11]
            NVP_ST_IDLE: if (start) state_nxt = NVP_ST_SEND;
            NVP_ST_SEND: if (accept && last_byte) state_nxt = NVP_ST_IDLE;
            default:     state_nxt = NVP_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= NVP_ST_BOOT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // A tick while a frame is still draining is dropped, not queued
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pay_r <= '0;
        end else if (start) begin
            pay_r <= pay_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_r      <= 6'h00;
            tx_data_r  <= 8'h00;
            tx_valid_r <= 1'b0;
        end else if (start) begin
            idx_r      <= 6'h00;
            tx_data_r  <= NVP_PREAMBLE_BYTE;                      // [R1]
            tx_valid_r <= 1'b1;
        end else if (accept) begin
            idx_r      <= idx_nxt;
            tx_data_r  <= byte_nxt;
            tx_valid_r <= !last_byte;
        end
    end

    // CRC covers type, length and payload, not the preamble
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_r <= CRC_INIT;
        end else if (start) begin
            crc_r <= CRC_INIT;
        end else if (accept && in_crc) begin
            crc_r <= crc_upd; // [R1]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_cnt_r <= 16'h0000;
        end else if (accept && last_byte) begin
            pkt_cnt_r <= pkt_cnt_r + 16'h0001;
        end
    end

endmodule : nvp_framer

//--- tb/nvp_framer_properties.sv
`timescale 1ns/1ps
module nvp_framer_properties (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_we,
    input wire logic        reg_re,
    input wire logic [15:0] reg_rdata_r,
    input wire logic [7:0]  tx_data_r,
    input wire logic        tx_valid_r,
    input wire logic        tx_ready,
    input wire logic [1:0]  baud_sel_r,
    input wire logic [1:0]  gyro_cut_r
);
    logic [5:0] cnt_r;
    wire logic [7:0] hdr = (cnt_r < 6'h02) ? 8'h55 : (cnt_r == 6'h02) ?
        8'h4E : (cnt_r == 6'h03) ? 8'h31 : 8'h2A;
    wire logic [1:0] band = (reg_wdata >= 16'h1BE6) ? 2'h0 :
        (reg_wdata >= 16'h0DF3) ? 2'h1 : (reg_wdata >= 16'h05FA) ? 2'h2 : 2'h3;
    wire logic set_baud = reg_we && reg_addr == 8'h02;
    // Bytes taken in this frame; cleared while the stream is idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_r <= 6'h00;
        else if (tx_valid_r && tx_ready) cnt_r <= cnt_r + 6'h01;
        else if (!tx_valid_r) cnt_r <= 6'h00;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_HOLD: assert property (tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
        else $error("byte dropped before accept");
    AST_HDR: assert property (tx_valid_r && cnt_r < 6'h05 |-> tx_data_r == hdr)
        else $error("bad frame header");
    AST_LEN: assert property ($fell(tx_valid_r) |-> cnt_r == 6'h31)
        else $error("bad frame length");
    AST_BAUD: assert property (set_baud && reg_wdata <= 16'h0003 |-> ##2 baud_sel_r == $past(reg_wdata[1:0], 2))
        else $error("rate not applied");
    AST_BAUD_REJ: assert property (set_baud && reg_wdata > 16'h0003 |-> ##2 $stable(baud_sel_r))
        else $error("bad rate applied");
    AST_STORED: assert property (reg_we && reg_addr == 8'h12 |-> ##2 $stable(baud_sel_r))
        else $error("stored write acted now");
    AST_GYRO: assert property (reg_we && reg_addr == 8'h05 |-> ##2 gyro_cut_r == $past(band, 2))
        else $error("bad cutoff band");
    AST_RDHOLD: assert property (!reg_re |=> $stable(reg_rdata_r))
        else $error("read data moved");
endmodule : nvp_framer_properties

//--- tb/nvp_host_model.sv
`timescale 1ns/1ps
module nvp_host_model (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       slow,
    input wire logic [7:0] tx_data_r,
    input wire logic       tx_valid_r,
    output logic           tx_ready
);
    logic [7:0] rx_q [$];
    // Stall every other cycle, as a slow line would
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) tx_ready <= 1'b0;
        else tx_ready <= slow ? !tx_ready : 1'b1;
    end
    // Keep each taken byte; framing and CRC judged by the bench
    always @(posedge clk)
        if (rst_n && tx_valid_r && tx_ready) rx_q.push_back(tx_data_r);
endmodule : nvp_host_model

//--- tb/test_nvp_framer.sv
`timescale 1ns/1ps
module test_nvp_framer;
    import nvp_pkg::*;
    logic             clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0;
    logic [7:0]       addr = 8'h00, txd, f [49];
    logic [15:0]      wd = 16'h0000, rdata, crc;
    logic [0:41][7:0] p;
    logic             txv, txr;
    logic [1:0]       baud, gcut, acut;
    logic [8:0]       ori;
    logic [5:0]       bhv;
    int               err_total = 0, checks = 0;
    logic [47:0] tbl [12] = '{48'h02000302_0003, 48'h02000402_0003,
        48'h12000012_0000, 48'h12000102_0003, 48'h01000301_0001,
        48'h034E3003_4E31, 48'h07000107_0009, 48'h07016C07_016C,
        48'h08003F08_003F, 48'h0BFFFF1B_8000, 48'h09800009_8000,
        48'h2F12342F_0000};
    logic [15:0] dv [8] = '{16'h0000, 16'h0002, 16'h0005, 16'h000A,
        16'h0014, 16'h0019, 16'h0032, 16'h0001};
    logic [19:0] flt [6] = '{20'h1BE60, 20'h1BE51, 20'h0DF31, 20'h0DF22,
        20'h05FA2, 20'h05F93};
    always #5 clk = ~clk;
    nvp_framer #(.BASE_TICK_CYC(200)) nvp_framer_i (.clk(clk), .rst_n(rst_n),
        .reg_addr(addr), .reg_wdata(wd), .reg_we(we), .reg_re(re),
        .reg_rdata_r(rdata), .roll_word(p[0:1]), .pitch_word(p[2:3]),
        .true_heading_word(p[4:5]), .x_rate_word(p[6:7]),
        .y_rate_word(p[8:9]), .z_rate_word(p[10:11]),
        .x_accel_word(p[12:13]), .y_accel_word(p[14:15]),
        .z_accel_word(p[16:17]), .north_velocity_word(p[18:19]),
        .east_velocity_word(p[20:21]), .down_velocity_word(p[22:23]),
        .sat_longitude_word(p[24:27]), .sat_latitude_word(p[28:31]),
        .sat_altitude_word(p[32:33]), .rate_sensor_temp_word(p[34:35]),
        .time_of_week_ms(p[36:39]), .master_health_word(p[40:41]),
        .tx_data_r(txd), .tx_valid_r(txv), .tx_ready(txr),
        .baud_sel_r(baud), .gyro_cut_r(gcut), .accel_cut_r(acut),
        .orient_r(ori), .behav_r(bhv));
    nvp_host_model host (.clk(clk), .rst_n(rst_n), .slow(1'b1),
        .tx_data_r(txd), .tx_valid_r(txv), .tx_ready(txr));
    task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic wr(logic [7:0] a, logic [15:0] d);
        addr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [15:0] e);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
        cmp("rdata", e, rdata);
    endtask : rd
    task automatic complete_run();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 42; i++) p[i] <= 8'h10 + 8'(i);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h12, 16'h0002);
        rd(8'h03, 16'h4E31);
        foreach (tbl[k]) begin
            wr(tbl[k][47:40], tbl[k][39:24]);
            rd(tbl[k][23:16], tbl[k][15:0]);
        end
        cmp("orient", 16'h016C, 16'(ori));
        cmp("behav", 16'h003F, 16'(bhv));
        cmp("baud", 16'h0003, 16'(baud));
        foreach (dv[k]) begin
            wr(8'h01, dv[k]);
            rd(8'h01, dv[k]);
        end
        foreach (flt[j]) begin
            wr(8'h05, flt[j][19:4]);
            wr(8'h06, flt[j][19:4]);
            @(posedge clk);
            cmp("gyro_cut", 16'(flt[j][3:0]), 16'(gcut));
            cmp("accel_cut", 16'(flt[j][3:0]), 16'(acut));
        end
        // Capture from a frame start
        while (txv) @(posedge clk);
        host.rx_q.delete();
        {f[0], f[1], f[2], f[3], f[4]} = 40'h55554E312A;
        crc = NVP_CRC_INIT;
        for (int i = 2; i < 47; i++) begin
            if (i >= 5) f[i] = p[i - 5];
            crc = crc ^ {f[i], 8'h00};
            for (int b = 0; b < 8; b++)
                crc = {crc[14:0], 1'b0} ^ (crc[15] ? NVP_CRC_POLY : 16'h0000);
        end
        {f[47], f[48]} = crc;
        for (int n = 0; n < 1000 && host.rx_q.size() < 49; n++) @(posedge clk);
        for (int i = 0; i < 49; i++)
            cmp("frame", 16'(f[i]), 16'(host.rx_q[i]));
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule : test_nvp_framer
bind nvp_framer nvp_framer_properties nvp_framer_properties_i (.clk(clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_r(reg_rdata_r),
    .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r), .tx_ready(tx_ready),
    .baud_sel_r(baud_sel_r), .gyro_cut_r(gyro_cut_r));
